// >>> rtl/dpb_pkg.sv
// constants for the dual-port dma buffer ram
// assumes one 50 MHz clock shared by cpu and dma ports
// Notes on behaviour
// - 1 Kbyte dual-port buffer at top of y space
// - both ports access same cycle, separate addresses
// - dma access never steals cpu cycles
// - same-location concurrent writes: cpu wins
// - no wait state or stall toward cpu
// - byte write touches only selected lane
// - buffer base fixed per variant, not programmable
package dpb_pkg;
    // ****************************************
    // sizes and map
    // ****************************************
    localparam int unsigned DPB_BYTES      = 1024;
    localparam int unsigned DPB_DATA_W     = 16;
    localparam int unsigned DPB_ADDR_W     = 16;
    localparam int unsigned DPB_WORDS      = DPB_BYTES / 2;
    localparam int unsigned DPB_IDX_W      = $clog2(DPB_WORDS);
    // default top of y data space, last byte address of the buffer
    localparam logic [15:0] DPB_Y_TOP      = 16'h27ff;
    localparam logic [15:0] DPB_BASE_DFLT  = 16'h2400;
    localparam logic [15:0] DPB_RESET_DATA = 16'h0000;
    localparam int unsigned DPB_CLK_HZ     = 50_000_000;
endpackage

// >>> rtl/dpb_ram.sv
// two-port word memory with byte lane write enables
// assumes caller resolves write collisions before this module
`timescale 1ns/1ps
module dpb_ram
    import dpb_pkg::*;
#(
    parameter int unsigned WORDS = DPB_WORDS,
    parameter int unsigned IDX_W = DPB_IDX_W
) (
    input  wire logic                  core_clk_i, // system clock
    input  wire logic [IDX_W-1:0]      a_idx_i,    // port a word index
    input  wire logic [1:0]            a_we_i,     // port a lane enables
    input  wire logic [DPB_DATA_W-1:0] a_wd_i,     // port a write data
    output logic      [DPB_DATA_W-1:0] a_rd_o,     // port a read data
    input  wire logic [IDX_W-1:0]      b_idx_i,    // port b word index
    input  wire logic [1:0]            b_we_i,     // port b lane enables
    input  wire logic [DPB_DATA_W-1:0] b_wd_i,     // port b write data
    output logic      [DPB_DATA_W-1:0] b_rd_o      // port b read data
);
    logic [DPB_DATA_W-1:0] mem [WORDS];

    // the index must reach every word and no more
    if (WORDS != (2 ** IDX_W)) begin : g_bad_depth
        $error("word count must fill the index range");
    end

    // ****************************************
    // storage
    // ****************************************
    // read returns old contents; write-through would make a path port to port
    // one process owns the array, so both ports and both lanes are written here
    always_ff @(posedge core_clk_i) begin
        a_rd_o <= mem[a_idx_i];
        b_rd_o <= mem[b_idx_i];
        for (int l = 0; l < 2; l++) begin
            if (a_we_i[l]) begin
                mem[a_idx_i][l*8 +: 8] <= a_wd_i[l*8 +: 8];
            end
            if (b_we_i[l]) begin
                mem[b_idx_i][l*8 +: 8] <= b_wd_i[l*8 +: 8];
            end
        end
    end
endmodule

// >>> rtl/dpb_top.sv
// dual-port dma buffer: cpu port and dma port on one shared ram
// assumes both masters sit on core_clk_i; reads return one cycle later
// assumes the buffer base is tied per variant by parameter, never by software
`timescale 1ns/1ps
module dpb_top
    import dpb_pkg::*;
#(
    parameter logic [15:0] BASE_ADDR = DPB_BASE_DFLT // fixed per variant
) (
    input  wire logic                  core_clk_i,  // system clock
    input  wire logic                  rst_i,       // sync reset, high
    input  wire logic                  cpu_rd_i,    // cpu read strobe
    input  wire logic                  cpu_wr_i,    // cpu write strobe
    input  wire logic                  cpu_byte_i,  // cpu byte access
    input  wire logic [DPB_ADDR_W-1:0] cpu_addr_i,  // cpu byte address
    input  wire logic [DPB_DATA_W-1:0] cpu_wdata_i, // cpu write data
    output logic      [DPB_DATA_W-1:0] cpu_rdata_o, // cpu read data
    output logic                       cpu_hit_o,   // cpu address in buffer
    output logic                       cpu_stall_o, // always low
    input  wire logic                  dma_rd_i,    // dma read strobe
    input  wire logic                  dma_wr_i,    // dma write strobe
    input  wire logic                  dma_byte_i,  // dma byte access
    input  wire logic [DPB_ADDR_W-1:0] dma_addr_i,  // dma byte address
    input  wire logic [DPB_DATA_W-1:0] dma_wdata_i, // dma write data
    output logic      [DPB_DATA_W-1:0] dma_rdata_o, // dma read data
    output logic                       dma_valid_o, // dma read data valid
    output logic                       dma_drop_o   // dma write lost to cpu
);
    // ****************************************
    // elaboration checks
    // ****************************************
    // window mask; only right while the buffer is a power of two on its own boundary
    localparam logic [15:0] SPAN_MASK = 16'(DPB_BYTES - 1);
    localparam int unsigned LANES     = DPB_DATA_W / 8;

    if (DPB_BYTES != (2 ** (DPB_IDX_W + 1))) begin : g_bad_size
        $error("buffer size must be a power of two in bytes");
    end

    if ((BASE_ADDR & SPAN_MASK) != 16'h0000) begin : g_bad_align
        $error("buffer base must sit on a buffer-size boundary");
    end

    // the upper half of data space is not implemented memory
    if (BASE_ADDR[15]) begin : g_bad_half
        $error("buffer base must lie in the lower half of data space");
    end

    if (LANES != 2) begin : g_bad_width
        $error("ports are built for exactly two byte lanes");
    end

    // ****************************************
    // state and wires
    // ****************************************
    // read flags and the dma drop flag only; the word itself is held by the ram's output register
    typedef struct packed {
        logic       cpu_rd;
        logic       cpu_byte;
        logic       cpu_hi;
        logic       dma_rd;
        logic       dma_byte;
        logic       dma_hi;
        logic       dma_drop;
    } dpb_state_t;

    dpb_state_t st_r;
    dpb_state_t st_nxt;

    logic [DPB_IDX_W-1:0]  cpu_idx;
    logic [DPB_IDX_W-1:0]  dma_idx;
    logic                  cpu_in;
    logic                  dma_in;

    logic                  cpu_wr_ok;
    logic                  dma_wr_ok;
    logic [1:0]            cpu_we;
    logic [1:0]            dma_we;
    logic [1:0]            dma_we_raw;
    logic                  same_word;
    logic [1:0]            lane_clash;
    logic [DPB_DATA_W-1:0] cpu_wd;
    logic [DPB_DATA_W-1:0] dma_wd;
    logic [DPB_DATA_W-1:0] cpu_q;
    logic [DPB_DATA_W-1:0] dma_q;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic in_buf(input logic [15:0] a);
        logic [15:0] top;
        top    = BASE_ADDR | SPAN_MASK;
        in_buf = (a >= BASE_ADDR) && (a <= top);
    endfunction

    // bit 0 only picks the lane, so it plays no part in the index
    function automatic logic [DPB_IDX_W-1:0] word_idx(input logic [15:0] a);
        word_idx = a[DPB_IDX_W:1];
    endfunction

    function automatic logic [1:0] lanes(input logic byte_acc, input logic a0);
        if (!byte_acc) begin
            lanes = 2'b11;
        end else if (a0) begin
            lanes = 2'b10;
        end else begin
            lanes = 2'b01;
        end
    endfunction

    // byte data arrives in the low bits; copy it to both lanes, the enables pick one
    function automatic logic [15:0] wdat(input logic byte_acc, input logic [15:0] d);
        if (byte_acc) begin
            wdat = {d[7:0], d[7:0]};
        end else begin
            wdat = d;
        end
    endfunction

    // byte reads land in the low bits, zero-extended
    function automatic logic [15:0] rsel(input logic b, input logic hi, input logic [15:0] q);
        if (!b) begin
            rsel = q;
        end else if (hi) begin
            rsel = {8'h00, q[15:8]};
        end else begin
            rsel = {8'h00, q[7:0]};
        end
    endfunction

    // ****************************************
    // port decode
    // ****************************************
    assign cpu_in     = in_buf(cpu_addr_i);
    assign dma_in     = in_buf(dma_addr_i);
    assign cpu_idx    = word_idx(cpu_addr_i);
    assign dma_idx    = word_idx(dma_addr_i);
    // strobes outside the window are ignored; such writes go nowhere
    assign cpu_wr_ok  = cpu_wr_i && cpu_in;
    assign dma_wr_ok  = dma_wr_i && dma_in;
    assign cpu_we     = cpu_wr_ok ? lanes(cpu_byte_i, cpu_addr_i[0]) : 2'b00;
    assign dma_we_raw = dma_wr_ok ? lanes(dma_byte_i, dma_addr_i[0]) : 2'b00;
    assign cpu_wd     = wdat(cpu_byte_i, cpu_wdata_i);
    assign dma_wd     = wdat(dma_byte_i, dma_wdata_i);

    // ****************************************
    // write collision
    // ****************************************
    // lanes are only enabled inside the window, so the index alone decides
    assign same_word = (cpu_idx == dma_idx);

    // judged per lane: a cpu byte write leaves the other dma lane to land
    for (genvar l = 0; l < LANES; l++) begin : g_clash
        assign lane_clash[l] = same_word && cpu_we[l] && dma_we_raw[l];
        assign dma_we[l]     = dma_we_raw[l] && !lane_clash[l];
    end

    // ****************************************
    // cpu handshake
    // ****************************************
    // no path from dma activity to the cpu; the cpu write simply wins in place
    assign cpu_stall_o = 1'b0;
    assign cpu_hit_o   = cpu_in;

    // ****************************************
    // read flags
    // ****************************************
    always_comb begin
        st_nxt          = st_r;
        st_nxt.cpu_rd   = cpu_rd_i && cpu_in;
        st_nxt.cpu_byte = cpu_byte_i;
        st_nxt.cpu_hi   = cpu_addr_i[0];
        st_nxt.dma_rd   = dma_rd_i && dma_in;
        st_nxt.dma_byte = dma_byte_i;
        st_nxt.dma_hi   = dma_addr_i[0];
        st_nxt.dma_drop = |lane_clash;
        // ram contents survive reset; only the flags are cleared
        if (rst_i) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        st_r <= st_nxt;
    end

    // ****************************************
    // storage
    // ****************************************
    dpb_ram #(
        .WORDS (DPB_WORDS),
        .IDX_W (DPB_IDX_W)
    ) u_ram (
        .core_clk_i (core_clk_i),
        .a_idx_i    (cpu_idx),
        .a_we_i     (cpu_we),
        .a_wd_i     (cpu_wd),
        .a_rd_o     (cpu_q),
        .b_idx_i    (dma_idx),
        .b_we_i     (dma_we),
        .b_wd_i     (dma_wd),
        .b_rd_o     (dma_q)
    );

    // ****************************************
    // read data
    // ****************************************
    // out of range reads return zero, as unimplemented data space does
    always_comb begin
        cpu_rdata_o = DPB_RESET_DATA;
        dma_rdata_o = DPB_RESET_DATA;
        if (st_r.cpu_rd) begin
            cpu_rdata_o = rsel(st_r.cpu_byte, st_r.cpu_hi, cpu_q);
        end
        if (st_r.dma_rd) begin
            dma_rdata_o = rsel(st_r.dma_byte, st_r.dma_hi, dma_q);
        end
    end

    assign dma_valid_o = st_r.dma_rd;
    assign dma_drop_o  = st_r.dma_drop;
endmodule

// >>> test/dpb_props.sv
// checker for the dual-port buffer top
// assumes a bind onto dpb_top, one clock
`timescale 1ns/1ps
module dpb_props
    import dpb_pkg::*;
#(
    parameter logic [15:0] BASE_ADDR = DPB_BASE_DFLT
) (
    input wire logic        core_clk_i,  // clk
    input wire logic        rst_i,       // reset
    input wire logic        cpu_rd_i,    // rd
    input wire logic        cpu_wr_i,    // wr
    input wire logic [15:0] cpu_addr_i,  // addr
    input wire logic [15:0] cpu_rdata_o, // data
    input wire logic        cpu_hit_o,   // hit
    input wire logic        cpu_stall_o, // stall
    input wire logic        dma_rd_i,    // rd
    input wire logic        dma_wr_i,    // wr
    input wire logic [15:0] dma_addr_i,  // addr
    input wire logic        dma_valid_o, // valid
    input wire logic        dma_drop_o   // drop
);
    // ****
    // rules
    // ****
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire dhit = dma_addr_i[15:10] == BASE_ADDR[15:10];
    AST_NO_STALL: assert property (cpu_stall_o == 1'b0)
        else $error("cpu stall raised");
    AST_HIT_MAP: assert property (cpu_hit_o == (cpu_addr_i[15:10] == BASE_ADDR[15:10]))
        else $error("cpu hit wrong");
    AST_CLASH_DROP: assert property (cpu_wr_i && dma_wr_i && cpu_hit_o
        && cpu_addr_i == dma_addr_i |=> dma_drop_o) else $error("clash not dropped");
    AST_DROP_CAUSE: assert property (dma_drop_o |-> $past(cpu_wr_i) && $past(dma_wr_i)
        && ($past(cpu_addr_i) ^ $past(dma_addr_i)) < 16'h0002) else $error("bad drop");
    AST_LONE_WR: assert property (dma_wr_i && !cpu_wr_i |=> !dma_drop_o)
        else $error("lone dma write dropped");
    AST_DMA_VALID: assert property (dma_rd_i && dhit |=> dma_valid_o)
        else $error("dma read not valid");
    AST_VALID_CAUSE: assert property (dma_valid_o |-> $past(dma_rd_i))
        else $error("valid without read");
    AST_CPU_OOR: assert property (cpu_rd_i && !cpu_hit_o |=> cpu_rdata_o == 16'h0000)
        else $error("outside read not zero");
endmodule

// >>> test/dpb_dma_model.sv
// dma controller side of the buffer
// assumes 1-cycle read answer from dpb_top
`timescale 1ns/1ps
module dpb_dma_model (
    input  wire logic        core_clk_i,  // clk
    input  wire logic [15:0] dma_rdata_i, // data
    input  wire logic        dma_valid_i, // valid
    output logic             dma_rd_o,    // rd
    output logic             dma_wr_o,    // wr
    output logic             dma_byte_o,  // byte
    output logic [15:0]      dma_addr_o,  // addr
    output logic [15:0]      dma_wdata_o  // data
);
    initial {dma_rd_o, dma_wr_o, dma_byte_o, dma_addr_o, dma_wdata_o} = 35'h0;
    // buffer is both source and sink of peripheral data
    task automatic acc(input logic r, w, b, input logic [15:0] a, d,
                       output logic [15:0] q, output logic v);
        @(posedge core_clk_i) #1;
        {dma_rd_o, dma_wr_o, dma_byte_o, dma_addr_o, dma_wdata_o} = {r, w, b, a, d};
        @(posedge core_clk_i) #1;
        q = dma_rdata_i;
        v = dma_valid_i;
        {dma_rd_o, dma_wr_o} = 2'h0;
        dma_wdata_o = ~d; // no stale data on idle bus
    endtask
endmodule

// >>> test/tb_dual_port_dma_buffer_ram.sv
// bench for dpb_top with a dma model
// assumes 50 MHz clock, one-cycle reads
`timescale 1ns/1ps
module tb_dual_port_dma_buffer_ram;
    import dpb_pkg::*;
    logic core_clk_i = 0, rst_i = 1, cpu_rd_i = 0, cpu_wr_i = 0, cpu_byte_i = 0;
    logic [15:0] cpu_addr_i = 0, cpu_wdata_i = 0, cpu_rdata_o, dma_rdata_o, dma_addr_i;
    logic [15:0] dma_wdata_i, q, dq;
    logic cpu_hit_o, cpu_stall_o, dma_rd_i, dma_wr_i, dma_byte_i, dma_valid_o, dma_drop_o, v;
    int mismatches = 0, samples_checked = 0, cyc = 0;
    dpb_top dpb_top_i (.core_clk_i, .rst_i, .cpu_rd_i, .cpu_wr_i, .cpu_byte_i, .cpu_addr_i,
        .cpu_wdata_i, .cpu_rdata_o, .cpu_hit_o, .cpu_stall_o, .dma_rd_i, .dma_wr_i,
        .dma_byte_i, .dma_addr_i, .dma_wdata_i, .dma_rdata_o, .dma_valid_o, .dma_drop_o);
    dpb_dma_model dma_m (.core_clk_i, .dma_rdata_i(dma_rdata_o), .dma_valid_i(dma_valid_o),
        .dma_rd_o(dma_rd_i), .dma_wr_o(dma_wr_i), .dma_byte_o(dma_byte_i),
        .dma_addr_o(dma_addr_i), .dma_wdata_o(dma_wdata_i));
    // ****
    // tasks
    // ****
    task automatic chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cpu(input logic r, w, b, input logic [15:0] a, d);
        @(posedge core_clk_i) #1;
        {cpu_rd_i, cpu_wr_i, cpu_byte_i, cpu_addr_i, cpu_wdata_i} = {r, w, b, a, d};
        @(posedge core_clk_i) #1;
        q = cpu_rdata_o;
        {cpu_rd_i, cpu_wr_i} = 2'h0;
        cpu_wdata_i = ~d;
    endtask
    task automatic t_clash;
        fork cpu(0, 1, 0, 16'h2400, 16'h1234); dma_m.acc(0, 1, 0, 16'h2400, 16'hbeef, dq, v); join
        chk("drop", 16'h0001, {15'h0, dma_drop_o});
        chk("stall", 16'h0, {15'h0, cpu_stall_o});
        fork cpu(1, 0, 1, 16'h2401, 16'h0); dma_m.acc(1, 0, 0, 16'h2400, 16'h0, dq, v); join
        chk("cpu byte", 16'h0012, q);
        chk("dma word", 16'h1234, dq);
        chk("dma valid", 16'h0001, {15'h0, v});
    endtask
    task automatic t_cross;
        fork cpu(0, 1, 0, 16'h27fe, 16'ha5c3); dma_m.acc(0, 1, 0, 16'h2402, 16'h1111, dq, v); join
        chk("no drop", 16'h0, {15'h0, dma_drop_o});
        fork cpu(1, 0, 0, 16'h2402, 16'h0); dma_m.acc(1, 0, 0, 16'h27fe, 16'h0, dq, v); join
        chk("cpu read", 16'h1111, q);
        chk("dma read", 16'ha5c3, dq);
        chk("valid", 16'h0001, {15'h0, v});
    endtask
    task automatic t_lane;
        fork cpu(0, 1, 1, 16'h2405, 16'h0077); dma_m.acc(0, 1, 1, 16'h2404, 16'h0066, dq, v); join
        chk("lane drop", 16'h0, {15'h0, dma_drop_o});
        cpu(1, 0, 0, 16'h2404, 16'h0);
        chk("lanes", 16'h7766, q);
    endtask
    task automatic t_oor;
        fork cpu(1, 0, 0, 16'h2800, 16'h0); dma_m.acc(1, 0, 0, 16'h23fe, 16'h0, dq, v); join
        chk("cpu out", 16'h0, q);
        chk("dma out", 16'h0, dq);
        chk("hit", 16'h0, {15'h0, cpu_hit_o});
        chk("dma no valid", 16'h0, {15'h0, v});
    endtask
    task automatic t_rst;
        fork
            cpu(1, 0, 0, 16'h2400, 16'h0);
            begin
                @(posedge core_clk_i) #1;
                rst_i = 1;
            end
        join
        chk("rst rdata", 16'h0, q);
        @(posedge core_clk_i) #1;
        rst_i = 0;
        cpu(1, 0, 0, 16'h2400, 16'h0);
        chk("ram kept", 16'h1234, q);
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial forever #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        #1 rst_i = 0;
        t_clash();
        t_cross();
        t_lane();
        t_oor();
        t_rst();
        end_sim();
    end
endmodule
bind dpb_top dpb_props #(.BASE_ADDR(BASE_ADDR)) dpb_props_i (.core_clk_i, .rst_i, .cpu_rd_i,
    .cpu_wr_i, .cpu_addr_i, .cpu_rdata_o, .cpu_hit_o, .cpu_stall_o, .dma_rd_i, .dma_wr_i,
    .dma_addr_i, .dma_valid_o, .dma_drop_o);
